/* inc/fpc_pkg.sv */
// Constants, types and carriers for the flash protection and command object block
// What this block does
// - Disallowed program-flash scenario writes are discarded
// - Scenario transitions follow the fixed allowed table
// - Program-flash register reads the scenario in force
// - Data-flash size only grows, open only clears
// - Open bit set makes size irrelevant
// - Data-flash protection loaded from configuration byte at reset
// - Double fault at load gives full data-flash protection, scenario still loaded
// - Protected program or erase sets violation, no change
// - Data-flash block erase refused when any protection
// - Protected range from base, (size+1) times 256 bytes
// - Open at bit 7, size at bits 4:0
// - Six 16-bit words, indexed, byte-wide access
// - Writing 1 to complete flag launches, clears it
// - Object locked from launch until flag returns
// - Results land in object, read after completion
// - Indices 6 and 7 ignore writes, read zero
// - Word 0 code and address high, word 1 low, data after
// - Flag low means all bus writes to the object ignored
package fpc_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] FPC_OFF_PFPROT   = 8'h00;
  localparam logic [7:0] FPC_OFF_DATA_FLASH_PROTECT_REG   = 8'h04;
  localparam logic [7:0] FPC_OFF_FLASH_STATUS_REG    = 8'h08;
  localparam logic [7:0] FPC_OFF_INDEX    = 8'h0C;
  localparam logic [7:0] FPC_OFF_COB      = 8'h10;
  localparam logic [7:0] FPC_OFF_IRQ_ST   = 8'h14;
  localparam logic [7:0] FPC_OFF_IRQ_MASK = 8'h18;

  // Field positions
  localparam int FPC_DF_OPEN_BIT  = 7;
  localparam int FPC_FLASH_STATUS_REG_COMMAND_COMPLETE_FLAG   = 7;
  localparam int FPC_FLASH_STATUS_REG_VIOL   = 4;
  localparam int FPC_IRQ_DONE     = 0;
  localparam int FPC_IRQ_VIOL     = 1;
  localparam int FPC_COB_ZERO_BIT = 7;

  // Data-flash protected window
  localparam logic [22:0] FPC_DF_BASE       = 23'h10_0000;
  localparam int          FPC_DF_STEP_BYTES = 256;
  localparam int          FPC_DF_SHIFT      = $clog2(FPC_DF_STEP_BYTES);
  localparam int          FPC_DF_TOP        = FPC_DF_SHIFT + 5;
  localparam logic [22:0] FPC_CFG_DF_ADDR   = 23'h7F_FF0D;

  // Values after reset; the full size is also used after a faulty load
  localparam logic [2:0] FPC_PF_RST       = 3'h3;
  localparam logic [4:0] FPC_DF_SIZE_FULL = 5'h1F;

  // Command object geometry and word roles
  localparam logic [2:0] FPC_COB_WORDS   = 3'h6;
  localparam logic [2:0] FPC_IDX_ADDR_HI = 3'h0;
  localparam logic [2:0] FPC_IDX_ADDR_LO = 3'h1;

  // Data-flash command codes seen by the protection check
  localparam logic [7:0] FPC_CMD_ERASE_DBLK = 8'h10;
  localparam logic [7:0] FPC_CMD_PROG_D     = 8'h11;
  localparam logic [7:0] FPC_CMD_ERASE_DSEC = 8'h12;

  // Allowed scenario transitions, row per source, bit per target
  localparam logic [7:0][7:0] FPC_PF_ALLOWED = {8'hFF, 8'h5A, 8'h3C, 8'h18, 8'h08, 8'h0C, 8'h0A, 8'h0F};

  typedef enum logic [1:0] {FPC_LOAD, FPC_IDLE, FPC_CHECK, FPC_RUN} fpc_fsm_t;

  typedef struct packed {
    logic        valid;
    logic [22:0] addr;
  } fpc_cfg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] pf_byte;
    logic [7:0] df_byte;
    logic       dbl_fault;
  } fpc_cfg_rsp_t;

  typedef struct packed {
    logic            start;
    logic [7:0]      code;
    logic [22:0]     addr;
    logic [3:0][15:0] data;
  } fpc_exec_req_t;

  typedef struct packed {
    logic        done;
    logic        wr;
    logic [2:0]  idx;
    logic [15:0] data;
  } fpc_exec_rsp_t;

  typedef struct packed {
    fpc_fsm_t         fsm;
    logic [2:0]       pf_scen;
    logic             df_open;
    logic [4:0]       df_size;
    logic             command_complete_flag;
    logic             protection_violation_flag;
    logic [2:0]       idx;
    logic [5:0][15:0] cob;
    logic [1:0]       irq_st;
    logic [1:0]       irq_mask;
    logic             exec_start;
    logic [31:0]      prdata;
  } fpc_state_t;

  localparam fpc_state_t FPC_STATE_RST = '{
    fsm: FPC_LOAD, pf_scen: FPC_PF_RST, df_open: 1'b0, df_size: FPC_DF_SIZE_FULL,
    command_complete_flag: 1'b0, protection_violation_flag: 1'b0, idx: 3'h0, cob: '0, irq_st: 2'h0, irq_mask: 2'h0,
    exec_start: 1'b0, prdata: 32'h0000_0000};

endpackage : fpc_pkg

/* core/fpc_scen_check.sv */
// Program-flash protection scenario transition check
`timescale 1ns/1ps
module fpc_scen_check
  import fpc_pkg::*;
(
  input  wire logic [2:0] from_scen,
  input  wire logic [2:0] to_scen,
  output logic            allowed
);

  // Table lookup, row by current scenario, bit by requested one
  assign allowed = FPC_PF_ALLOWED[from_scen][to_scen];

endmodule : fpc_scen_check

/* core/fpc_top.sv */
// Flash protection registers and indexed command object with APB slave
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module fpc_top
  import fpc_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               irq,
  output fpc_cfg_req_t       cfg_req,
  input  wire fpc_cfg_rsp_t  cfg_rsp,
  output fpc_exec_req_t      exec_req,
  input  wire fpc_exec_rsp_t exec_rsp
);

  fpc_state_t  st;
  fpc_state_t  next_st;
  logic        setup;
  logic        wr_acc;
  logic        mapped;
  logic [31:0] rd_val;
  logic        pf_ok;
  logic [7:0]  cmd_code;
  logic [22:0] cmd_addr;
  logic [22:0] df_off;
  logic        in_df;
  logic        prot_hit;
  logic        viol;
  logic        idx_ok;
  logic        cob_wr_ok;

  // APB phases; zero wait states since read data is caught in setup
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = st.prdata;

  // Level interrupt from sticky status gated by mask
  assign irq = |(st.irq_st & st.irq_mask);

  // Configuration fetch requested for as long as the load is pending
  assign cfg_req.valid = (st.fsm == FPC_LOAD);
  assign cfg_req.addr  = FPC_CFG_DF_ADDR;

  // Command parameters come straight from the object flops
  assign exec_req.start = st.exec_start;
  assign exec_req.code  = st.cob[FPC_IDX_ADDR_HI][15:8];
  assign exec_req.addr  = cmd_addr;
  assign exec_req.data  = st.cob[5:2];

  // Scenario transition table
  fpc_scen_check u_scen (
    .from_scen (st.pf_scen),
    .to_scen   (pwdata[2:0]),
    .allowed   (pf_ok)
  );

  // Target address split across the first two words
  assign cmd_code = st.cob[FPC_IDX_ADDR_HI][15:8];
  assign cmd_addr = {st.cob[FPC_IDX_ADDR_HI][6:0], st.cob[FPC_IDX_ADDR_LO]};
  assign df_off   = cmd_addr - FPC_DF_BASE;

  // Window test avoids a multiplier: offset below (size+1) steps
  assign in_df = (cmd_addr >= FPC_DF_BASE) && (df_off[22:FPC_DF_TOP] == '0)
                 && (df_off[FPC_DF_TOP-1:FPC_DF_SHIFT] <= st.df_size);
  assign prot_hit = !st.df_open && in_df;

  // Violation: protected program or sector erase, or any block erase under protection
  assign viol = (((cmd_code == FPC_CMD_PROG_D) || (cmd_code == FPC_CMD_ERASE_DSEC)) && prot_hit)
                || ((cmd_code == FPC_CMD_ERASE_DBLK) && !st.df_open);

  // Implemented object words and the lock
  assign idx_ok    = (st.idx < FPC_COB_WORDS);
  assign cob_wr_ok = st.command_complete_flag && (st.fsm == FPC_IDLE) && idx_ok;

  // Read mux and address decode
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      FPC_OFF_PFPROT: begin
        rd_val[2:0] = st.pf_scen;
      end
      FPC_OFF_DATA_FLASH_PROTECT_REG: begin
        rd_val[FPC_DF_OPEN_BIT] = st.df_open;
        rd_val[4:0]             = st.df_size;
      end
      FPC_OFF_FLASH_STATUS_REG: begin
        rd_val[FPC_FLASH_STATUS_REG_COMMAND_COMPLETE_FLAG] = st.command_complete_flag;
        rd_val[FPC_FLASH_STATUS_REG_VIOL] = st.protection_violation_flag;
      end
      FPC_OFF_INDEX: begin
        rd_val[2:0] = st.idx;
      end
      FPC_OFF_COB: begin
        // Unused indices read as zero
        if (idx_ok) begin
          rd_val[15:0] = st.cob[st.idx];
        end
      end
      FPC_OFF_IRQ_ST: begin
        rd_val[1:0] = st.irq_st;
      end
      FPC_OFF_IRQ_MASK: begin
        rd_val[1:0] = st.irq_mask;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Next state: software writes first, hardware events after so a set beats a clear
  always_comb begin
    next_st            = st;
    next_st.exec_start = 1'b0;
    if (setup) begin
      next_st.prdata = rd_val;
    end
    if (wr_acc) begin
      case (paddr)
        FPC_OFF_PFPROT: begin
          // Illegal scenario is dropped silently
          if (pf_ok && (st.fsm != FPC_LOAD)) begin
            next_st.pf_scen = pwdata[2:0];
          end
        end
        FPC_OFF_DATA_FLASH_PROTECT_REG: begin
          // Protection may only be added
          if (st.fsm != FPC_LOAD) begin
            next_st.df_open = st.df_open && pwdata[FPC_DF_OPEN_BIT];
            if (pwdata[4:0] > st.df_size) begin
              next_st.df_size = pwdata[4:0];
            end
          end
        end
        FPC_OFF_FLASH_STATUS_REG: begin
          if (pwdata[FPC_FLASH_STATUS_REG_VIOL]) begin
            next_st.protection_violation_flag = 1'b0;
          end
          // Writing one to the complete flag launches the command
          if (pwdata[FPC_FLASH_STATUS_REG_COMMAND_COMPLETE_FLAG] && st.command_complete_flag && (st.fsm == FPC_IDLE)) begin
            next_st.command_complete_flag = 1'b0;
            next_st.fsm  = FPC_CHECK;
          end
        end
        FPC_OFF_INDEX: begin
          next_st.idx = pwdata[2:0];
        end
        FPC_OFF_COB: begin
          // Byte lanes land separately; locked writes vanish with no error
          if (cob_wr_ok) begin
            if (pstrb[1]) begin
              next_st.cob[st.idx][15:8] = pwdata[15:8];
            end
            if (pstrb[0]) begin
              next_st.cob[st.idx][7:0] = pwdata[7:0];
              if (st.idx == FPC_IDX_ADDR_HI) begin
                next_st.cob[st.idx][FPC_COB_ZERO_BIT] = 1'b0;
              end
            end
          end
        end
        FPC_OFF_IRQ_ST: begin
          next_st.irq_st = st.irq_st & ~pwdata[1:0];
        end
        FPC_OFF_IRQ_MASK: begin
          next_st.irq_mask = pwdata[1:0];
        end
        default: begin
        end
      endcase
    end
    case (st.fsm)
      FPC_LOAD: begin
        // Commands stay blocked until protection is loaded
        if (cfg_rsp.valid) begin
          next_st.pf_scen = cfg_rsp.pf_byte[2:0];
          if (cfg_rsp.dbl_fault) begin
            next_st.df_open = 1'b0;
            next_st.df_size = FPC_DF_SIZE_FULL;
          end else begin
            next_st.df_open = cfg_rsp.df_byte[FPC_DF_OPEN_BIT];
            next_st.df_size = cfg_rsp.df_byte[4:0];
          end
          next_st.command_complete_flag = 1'b1;
          next_st.fsm  = FPC_IDLE;
        end
      end
      FPC_IDLE: begin
      end
      FPC_CHECK: begin
        // Refused commands never reach the array
        if (viol) begin
          next_st.protection_violation_flag                = 1'b1;
          next_st.command_complete_flag                  = 1'b1;
          next_st.irq_st[FPC_IRQ_VIOL] = 1'b1;
          next_st.irq_st[FPC_IRQ_DONE] = 1'b1;
          next_st.fsm                   = FPC_IDLE;
        end else begin
          next_st.exec_start = 1'b1;
          next_st.fsm        = FPC_RUN;
        end
      end
      FPC_RUN: begin
        // Executor may return results into the object
        if (exec_rsp.wr && (exec_rsp.idx < FPC_COB_WORDS)) begin
          next_st.cob[exec_rsp.idx] = exec_rsp.data;
        end
        if (exec_rsp.done) begin
          next_st.command_complete_flag                  = 1'b1;
          next_st.irq_st[FPC_IRQ_DONE] = 1'b1;
          next_st.fsm                   = FPC_IDLE;
        end
      end
      default: begin
        next_st = FPC_STATE_RST;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= FPC_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // Checks on the design's own behaviour
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence seq_launch;
    wr_acc && (paddr == FPC_OFF_FLASH_STATUS_REG) && pwdata[FPC_FLASH_STATUS_REG_COMMAND_COMPLETE_FLAG] && st.command_complete_flag && (st.fsm == FPC_IDLE);
  endsequence

  sequence seq_check_fail;
    (st.fsm == FPC_CHECK) && viol;
  endsequence

  sequence seq_refused_end;
    st.protection_violation_flag && st.command_complete_flag && !exec_req.start;
  endsequence

  a_pf_bad_kept: assert property (
    wr_acc && (paddr == FPC_OFF_PFPROT) && !pf_ok && (st.fsm != FPC_LOAD)
    |=> st.pf_scen == $past(st.pf_scen))
    else $error("disallowed scenario write changed register");

  a_pf_good_taken: assert property (
    wr_acc && (paddr == FPC_OFF_PFPROT) && pf_ok && (st.fsm != FPC_LOAD)
    |=> st.pf_scen == $past(pwdata[2:0]))
    else $error("allowed scenario write not taken");

  a_pf_read_back: assert property (
    setup && (paddr == FPC_OFF_PFPROT) |=> prdata == {29'h0, $past(st.pf_scen)})
    else $error("scenario read mismatch");

  a_df_size_grows: assert property (
    (st.fsm != FPC_LOAD) |=> (st.df_size >= $past(st.df_size)) && !(st.df_open && !$past(st.df_open)))
    else $error("data flash protection was reduced");

  a_df_open_ignores: assert property (
    (st.fsm == FPC_CHECK) && st.df_open |=> exec_req.start)
    else $error("command refused while protection open");

  a_cfg_load: assert property (
    (st.fsm == FPC_LOAD) && cfg_rsp.valid && !cfg_rsp.dbl_fault
    |=> (st.df_open == $past(cfg_rsp.df_byte[7])) && (st.df_size == $past(cfg_rsp.df_byte[4:0])) && st.command_complete_flag)
    else $error("protection byte not loaded");

  a_cfg_fault: assert property (
    (st.fsm == FPC_LOAD) && cfg_rsp.valid && cfg_rsp.dbl_fault
    |=> !st.df_open && (st.df_size == 5'h1F))
    else $error("faulty load not fully protected");

  a_viol_flag: assert property (
    seq_check_fail |=> seq_refused_end)
    else $error("protected command not refused");

  a_blk_refuse: assert property (
    (st.fsm == FPC_CHECK) && (cmd_code == FPC_CMD_ERASE_DBLK) && !st.df_open |=> !exec_req.start && st.protection_violation_flag)
    else $error("block erase under protection started");

  a_window_edge: assert property (
    (st.fsm == FPC_CHECK) && !st.df_open && (cmd_code == FPC_CMD_PROG_D)
    && (df_off == {10'h000, st.df_size, 8'hFF}) && (cmd_addr >= FPC_DF_BASE) |=> st.protection_violation_flag)
    else $error("last protected byte not covered");

  a_launch_seq: assert property (
    seq_launch |=> !st.command_complete_flag ##1 (exec_req.start || st.protection_violation_flag))
    else $error("launch did not clear flag and proceed");

  a_cob_locked: assert property (
    wr_acc && (paddr == FPC_OFF_COB) && !st.command_complete_flag && !exec_rsp.wr |=> st.cob == $past(st.cob))
    else $error("command object changed while locked");

  a_run_locked: assert property (
    (st.fsm == FPC_RUN) && !exec_rsp.wr && !exec_rsp.done |=> $stable(st.cob) && !st.command_complete_flag)
    else $error("object or flag moved during command");

  a_cob_unused: assert property (
    setup && (paddr == FPC_OFF_COB) && !idx_ok |=> prdata == 32'h0000_0000)
    else $error("unused index read not zero");

  a_no_error_lock: assert property (
    wr_acc && (paddr == FPC_OFF_COB) && !cob_wr_ok |-> !pslverr)
    else $error("locked write raised an error");

  // Executor sees exactly one start per accepted launch
  a_start_pulse: assert property (
    exec_req.start |=> !exec_req.start)
    else $error("start pulse longer than one cycle");

  // Completion wins over a status clear in the same cycle
  a_done_flag: assert property (
    (st.fsm == FPC_RUN) && exec_rsp.done |=> st.command_complete_flag && st.irq_st[FPC_IRQ_DONE] && (st.fsm == FPC_IDLE))
    else $error("completion not flagged");

  a_viol_status: assert property (
    seq_check_fail |=> st.irq_st[FPC_IRQ_VIOL] && st.irq_st[FPC_IRQ_DONE])
    else $error("refusal did not raise status");

  a_idx_ignored: assert property (
    wr_acc && (paddr == FPC_OFF_COB) && !idx_ok && !exec_rsp.wr |=> $stable(st.cob))
    else $error("write to unused index changed object");

  // Protection and complete flag hold until the configuration byte arrives
  a_load_holds: assert property (
    (st.fsm == FPC_LOAD) && !cfg_rsp.valid |=> $stable(st.pf_scen) && $stable(st.df_size) && !st.command_complete_flag)
    else $error("protection moved before load");

endmodule : fpc_top

/* dv/fpc_tb.sv */
// Self-checking bench for the flash protection and command object block
`timescale 1ns/1ps
module flash_protect_and_command_object_test;
  import fpc_pkg::*;

  logic          core_clk, nrst, psel, penable, pwrite, pready, pslverr, irq, err_v, got;
  logic [7:0]    paddr, df, code;
  logic [31:0]   pwdata, prdata, rd_v, seed;
  logic [3:0]    pstrb;
  logic [22:0]   a;
  logic [15:0]   d;
  logic [1:0]    mask, st;
  fpc_cfg_req_t  cfg_req;
  fpc_cfg_rsp_t  cfg_rsp;
  fpc_exec_req_t exec_req;
  fpc_exec_rsp_t exec_rsp;
  int            n_fail, checks_done, cyc;
  logic [7:0]    dw [5] = '{8'h83, 8'h89, 8'h09, 8'h8A, 8'h05};
  logic [7:0]    de [5] = '{8'h85, 8'h89, 8'h09, 8'h0A, 8'h0A};
  logic [7:0]    cd [4] = '{8'h10, 8'h11, 8'h12, 8'h20};

  fpc_top u_dut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .exec_req(exec_req), .exec_rsp(exec_rsp));

  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Hang guard, far above the expected run length
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Allowed targets per source scenario, one bit per target
  function automatic logic [7:0] allow(input int s);
    logic [7:0] m [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};
    return m[s];
  endfunction : allow

  // Open bit set means nothing protected
  function automatic logic viol_exp(input logic [7:0] c, input logic [22:0] ad, input logic [7:0] p);
    if (p[7]) return 1'b0;
    if (c == 8'h10) return 1'b1;
    return (c == 8'h11 || c == 8'h12) && int'(ad) >= 'h10_0000 && int'(ad) < 'h10_0000 + (int'(p[4:0]) + 1) * 256;
  endfunction : viol_exp

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One APB transfer; waits for pready, takes data at that edge
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] s);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] ad, input logic [31:0] dt);
    apb(1'b1, ad, dt, 4'hF);
  endtask : wr

  task rdchk(input string name, input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0, 4'h0);
    chk(name, rd_v, exp);
  endtask : rdchk

  // Reset, then answer the configuration load
  task do_reset(input logic [7:0] pf, input logic [7:0] dp, input logic dbl);
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    chk("cfg_valid", cfg_req.valid, 1'b1);
    chk("cfg_addr", cfg_req.addr, 23'h7F_FF0D);
    chk("rst_irq", irq, 1'b0);
    chk("rst_start", exec_req.start, 1'b0);
    chk("rst_ready", pready, 1'b1);
    cfg_rsp <= '{valid: 1'b1, pf_byte: pf, df_byte: dp, dbl_fault: dbl};
    @(posedge core_clk);
    cfg_rsp.valid <= 1'b0;
  endtask : do_reset

  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    cfg_rsp = '0;
    exec_rsp = '0;
    seed = 32'hCDE67762;
    // Every source and target scenario
    for (int s = 0; s < 8; s++) begin
      for (int t = 0; t < 8; t++) begin
        do_reset(8'(s), 8'h80, 1'b0);
        wr(FPC_OFF_PFPROT, 32'(t));
        rdchk("pf_scen", FPC_OFF_PFPROT, ((allow(s) >> t) & 8'h01) != 8'h00 ? t : s);
      end
    end
    // Data-flash protection only tightens
    do_reset(8'h07, 8'h85, 1'b0);
    rdchk("df_load", FPC_OFF_DATA_FLASH_PROTECT_REG, 32'h85);
    for (int i = 0; i < 5; i++) begin
      wr(FPC_OFF_DATA_FLASH_PROTECT_REG, 32'(dw[i]));
      rdchk("df_prot", FPC_OFF_DATA_FLASH_PROTECT_REG, 32'(de[i]));
    end
    do_reset(8'h07, 8'h80, 1'b1);
    rdchk("df_fault", FPC_OFF_DATA_FLASH_PROTECT_REG, 32'h1F);
    // Command object words, including the unused indices
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wr(FPC_OFF_INDEX, 32'(i));
      rdchk("index", FPC_OFF_INDEX, 32'(i));
      wr(FPC_OFF_COB, seed);
      rdchk("cob", FPC_OFF_COB, i > 5 ? 0 : i == 0 ? seed[15:0] & 16'hFF7F : seed[15:0]);
    end
    wr(FPC_OFF_INDEX, 32'h3);
    wr(FPC_OFF_COB, seed);
    apb(1'b1, FPC_OFF_COB, 32'h0000_A55A, 4'h1);
    rdchk("cob_lane", FPC_OFF_COB, {seed[15:8], 8'h5A});
    chk("exec_data", exec_req.data[1], {seed[15:8], 8'h5A});
    apb(1'b0, 8'h1C, 32'h0, 4'h0);
    chk("unmapped_err", err_v, 1'b1);
    chk("unmapped_rd", rd_v, 32'h0);
    // Launches with random protection, code and address
    for (int i = 0; i < 14; i++) begin
      seed = lfsr(seed);
      df = {seed[7], 2'b00, seed[4:0]};
      code = cd[seed[9:8]];
      a = FPC_DF_BASE + 23'(seed[23:10]);
      // Window edge both sides, then block erase protected and open
      if (i < 4) begin
        df = i < 3 ? 8'h00 : 8'h80;
        code = i < 2 ? 8'h11 : 8'h10;
        a = i == 0 ? 23'h10_00FF : 23'h10_0100;
      end
      mask = seed[25:24];
      do_reset(8'h07, df, 1'b0);
      wr(FPC_OFF_IRQ_MASK, 32'(mask));
      wr(FPC_OFF_INDEX, 32'h0);
      wr(FPC_OFF_COB, {16'h0, code, 1'b0, a[22:16]});
      wr(FPC_OFF_INDEX, 32'h1);
      wr(FPC_OFF_COB, {16'h0, a[15:0]});
      wr(FPC_OFF_FLASH_STATUS_REG, 32'h80);
      got = 1'b0;
      repeat (4) begin
        @(posedge core_clk);
        if (exec_req.start === 1'b1) got = 1'b1;
      end
      chk("started", got, !viol_exp(code, a, df));
      if (got) begin
        chk("code", exec_req.code, code);
        chk("addr", exec_req.addr, a);
        apb(1'b0, FPC_OFF_FLASH_STATUS_REG, 32'h0, 4'h0);
        chk("flag_busy", rd_v & 32'h90, 32'h0);
        wr(FPC_OFF_COB, 32'hFFFF);
        d = seed[31:16];
        exec_rsp <= '{done: 1'b0, wr: 1'b1, idx: 3'h2, data: d};
        @(posedge core_clk);
        exec_rsp <= '{done: 1'b1, wr: 1'b0, idx: 3'h0, data: 16'h0};
        @(posedge core_clk);
        exec_rsp <= '0;
        apb(1'b0, FPC_OFF_FLASH_STATUS_REG, 32'h0, 4'h0);
        chk("flag_done", rd_v & 32'h90, 32'h80);
        rdchk("cob_locked", FPC_OFF_COB, a[15:0]);
        wr(FPC_OFF_INDEX, 32'h2);
        rdchk("result", FPC_OFF_COB, d);
        st = 2'b01;
      end else begin
        apb(1'b0, FPC_OFF_FLASH_STATUS_REG, 32'h0, 4'h0);
        chk("viol_set", rd_v & 32'h90, 32'h90);
        wr(FPC_OFF_FLASH_STATUS_REG, 32'h10);
        apb(1'b0, FPC_OFF_FLASH_STATUS_REG, 32'h0, 4'h0);
        chk("viol_clr", rd_v & 32'h90, 32'h80);
        st = 2'b11;
      end
      chk("irq_on", irq, |(st & mask));
      rdchk("irq_st", FPC_OFF_IRQ_ST, st);
      wr(FPC_OFF_IRQ_ST, 32'h3);
      // Clear lands at the access edge, so look one cycle later
      @(posedge core_clk);
      chk("irq_off", irq, 1'b0);
    end
    wrap_up();
  end
endmodule : flash_protect_and_command_object_test
